/* afbi_cfg.svh */
// Constants for the asynchronous flash bus host: pin timing and field sizes.
// Assumes a 50 MHz system clock; all counts derive from the clock period.
`ifndef AFBI_CFG_SVH
`define AFBI_CFG_SVH

// ----------------------------------------------------------------------
// Clock, address, data and counter sizing
// ----------------------------------------------------------------------
`define AFBI_CLK_NS 20
`define AFBI_TOP_ADDR_MIN 18
`define AFBI_TOP_ADDR_MAX 21
`define AFBI_DATA_W 16
`define AFBI_CNT_W 8

// ----------------------------------------------------------------------
// Pin timing in ns, and least cycle counts rounded up
// ----------------------------------------------------------------------
`define AFBI_T_SETUP_NS 40
`define AFBI_T_STROBE_NS 60
`define AFBI_T_HOLD_NS 20
`define AFBI_T_ACCESS_NS 90
`define AFBI_T_RESET_NS 100
`define AFBI_T_WAKE_NS 150
`define AFBI_SYNC_STAGES 2
`define AFBI_SETUP_CYC ((`AFBI_T_SETUP_NS + `AFBI_CLK_NS - 1) / `AFBI_CLK_NS)
`define AFBI_STROBE_CYC ((`AFBI_T_STROBE_NS + `AFBI_CLK_NS - 1) / `AFBI_CLK_NS)
`define AFBI_HOLD_CYC ((`AFBI_T_HOLD_NS + `AFBI_CLK_NS - 1) / `AFBI_CLK_NS)
`define AFBI_READ_CYC (((`AFBI_T_ACCESS_NS + `AFBI_CLK_NS - 1) / `AFBI_CLK_NS) + `AFBI_SYNC_STAGES)
`define AFBI_RESET_CYC ((`AFBI_T_RESET_NS + `AFBI_CLK_NS - 1) / `AFBI_CLK_NS)
`define AFBI_WAKE_CYC ((`AFBI_T_WAKE_NS + `AFBI_CLK_NS - 1) / `AFBI_CLK_NS)

`endif

/* afbi_flash_model.sv */
// Behavioural flash device for the host bench: tiny array, pin rules only.
// Assumes one host drives every control pin; lock commands not modelled.
module afbi_flash_model (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic reset_powerdown_n,
  input wire logic vpp_en,
  input wire logic [21:0] addr,
  input wire logic [15:0] host_dq,
  input wire logic host_oe,
  output logic [15:0] dq_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:15];
  logic [3:0] idx;
  logic drive;
  // --------------------------------------------------------------------
  // Array and pins
  // --------------------------------------------------------------------
  assign idx = {addr[21], addr[2:0]}; // Top bit reaches the array
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 16'hC000 | 16'(i);
    end
  end
  // Capture on strobe rise; held reset or supply off blocks it
  always @(posedge we_n) begin
    if (!ce_n && reset_powerdown_n && vpp_en) begin
      mem[idx] <= host_dq; // Address used at this edge only
    end
  end
  // Always in read-array mode, so a wake needs no command
  assign drive = reset_powerdown_n && !ce_n && !oe_n;
  // Undriven bus shows the inverse, so stale data never matches
  assign dq_pin = host_oe ? host_dq : (drive ? mem[idx] : ~mem[idx]);
endmodule

/* afbi_host.sv */
// Host controller for an asynchronous 16-bit parallel flash: read and
// write cycles, reset/power-down, protect pin and program supply switch.
// Assumes dq_in comes from the pad (async) and user ports are on ref_clk.
//
// Behaviour
// - address width set by top_address_bit, 18..21.
// - host drives data only in write cycles.
// - command taken only with select and strobe low.
// - address and data valid at strobe rising edge.
`include "afbi_cfg.svh"
module afbi_host #(
  parameter int ADDR_TOP = 21
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [ADDR_TOP:0] cmd_addr,
  input wire afbi_pkg::afbi_data_t cmd_wdata,
  output afbi_pkg::afbi_data_t rd_data,
  output logic rd_valid,
  input wire logic pdown_req,
  input wire logic protect_en,
  input wire logic vpp_req,
  output logic pdown_active,
  output logic [ADDR_TOP:0] flash_addr,
  input wire afbi_pkg::afbi_data_t flash_dq_in,
  output afbi_pkg::afbi_data_t flash_dq_out,
  output logic flash_dq_oe,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_reset_powerdown_n,
  output logic flash_wp_n,
  output logic flash_vpp_en
);
  import afbi_pkg::*;

  // ----------------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------------
  // Only the four documented densities are served
  if (ADDR_TOP < `AFBI_TOP_ADDR_MIN || ADDR_TOP > `AFBI_TOP_ADDR_MAX) begin : g_bad_width
    $error("ADDR_TOP must lie between 18 and 21");
  end

  afbi_regs_t s_q;
  afbi_regs_t s_d;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Sequencer for write, read, power-down and wake
  always_comb begin
    s_d = s_q;
    s_d.rd_valid = 1'b0;
    // Pad data passes two flops before use
    s_d.dq_s1 = flash_dq_in;
    s_d.dq_s2 = s_q.dq_s1;
    // Protect level and supply switch follow the user controls
    s_d.wp_n = ~protect_en;
    s_d.vpp_en = vpp_req;
    case (s_q.st)
      AFBI_IDLE: begin
        if (pdown_req) begin
          s_d.st = AFBI_PDOWN;
          s_d.reset_powerdown_n = 1'b0;
          s_d.pdown = 1'b1;
          s_d.ready = 1'b0;
          s_d.cnt = afbi_cnt_t'(`AFBI_RESET_CYC);
        end else if (cmd_valid && s_q.ready) begin
          s_d.ready = 1'b0;
          s_d.addr = '0;
          s_d.addr[ADDR_TOP:0] = cmd_addr;
          s_d.ce_n = 1'b0;
          if (cmd_write) begin
            s_d.wdata = cmd_wdata;
            s_d.dq_oe = 1'b1;
            s_d.st = AFBI_SETUP;
            s_d.cnt = afbi_cnt_t'(`AFBI_SETUP_CYC);
          end else begin
            s_d.oe_n = 1'b0;
            s_d.st = AFBI_READ;
            s_d.cnt = afbi_cnt_t'(`AFBI_READ_CYC);
          end
        end
      end
      AFBI_SETUP: begin
        // Address and data settle before the strobe falls
        s_d.cnt = s_q.cnt - afbi_cnt_t'(1);
        if (s_q.cnt == afbi_cnt_t'(1)) begin
          s_d.we_n = 1'b0;
          s_d.st = AFBI_STROBE;
          s_d.cnt = afbi_cnt_t'(`AFBI_STROBE_CYC);
        end
      end
      AFBI_STROBE: begin
        s_d.cnt = s_q.cnt - afbi_cnt_t'(1);
        if (s_q.cnt == afbi_cnt_t'(1)) begin
          s_d.we_n = 1'b1;
          s_d.st = AFBI_HOLD;
          s_d.cnt = afbi_cnt_t'(`AFBI_HOLD_CYC);
        end
      end
      AFBI_HOLD: begin
        // Keep address and data after the rising strobe edge
        s_d.cnt = s_q.cnt - afbi_cnt_t'(1);
        if (s_q.cnt == afbi_cnt_t'(1)) begin
          s_d.ce_n = 1'b1;
          s_d.dq_oe = 1'b0;
          s_d.ready = 1'b1;
          s_d.st = AFBI_IDLE;
        end
      end
      AFBI_READ: begin
        // Count covers access time plus the two sync stages
        s_d.cnt = s_q.cnt - afbi_cnt_t'(1);
        if (s_q.cnt == afbi_cnt_t'(1)) begin
          s_d.rdata = s_q.dq_s2;
          s_d.rd_valid = 1'b1;
          s_d.ce_n = 1'b1;
          s_d.oe_n = 1'b1;
          s_d.ready = 1'b1;
          s_d.st = AFBI_IDLE;
        end
      end
      AFBI_PDOWN: begin
        // Minimum low time, then stay while the user asks
        if (s_q.cnt > afbi_cnt_t'(1)) begin
          s_d.cnt = s_q.cnt - afbi_cnt_t'(1);
        end else if (!pdown_req) begin
          s_d.reset_powerdown_n = 1'b1;
          s_d.pdown = 1'b0;
          s_d.st = AFBI_WAKE;
          s_d.cnt = afbi_cnt_t'(`AFBI_WAKE_CYC);
        end
      end
      AFBI_WAKE: begin
        // No command until the device has recovered
        s_d.cnt = s_q.cnt - afbi_cnt_t'(1);
        if (s_q.cnt == afbi_cnt_t'(1)) begin
          s_d.ready = 1'b1;
          s_d.st = AFBI_IDLE;
        end
      end
      default: begin
        s_d.st = AFBI_IDLE;
        s_d.ce_n = 1'b1;
        s_d.oe_n = 1'b1;
        s_d.we_n = 1'b1;
        s_d.dq_oe = 1'b0;
        s_d.ready = 1'b1;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Reset holds the flash in reset too, so it leaves locked and in read mode
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.st <= AFBI_PDOWN;
      s_q.cnt <= afbi_cnt_t'(`AFBI_RESET_CYC);
      s_q.ce_n <= 1'b1;
      s_q.oe_n <= 1'b1;
      s_q.we_n <= 1'b1;
      s_q.reset_powerdown_n <= 1'b0;
      s_q.pdown <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state word
  assign cmd_ready = s_q.ready;
  assign rd_data = s_q.rdata;
  assign rd_valid = s_q.rd_valid;
  assign pdown_active = s_q.pdown;
  assign flash_addr = s_q.addr[ADDR_TOP:0];
  assign flash_dq_out = s_q.wdata;
  assign flash_dq_oe = s_q.dq_oe;
  assign flash_ce_n = s_q.ce_n;
  assign flash_oe_n = s_q.oe_n;
  assign flash_we_n = s_q.we_n;
  assign flash_reset_powerdown_n = s_q.reset_powerdown_n;
  assign flash_wp_n = s_q.wp_n;
  assign flash_vpp_en = s_q.vpp_en;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_strobe_low;
    !flash_we_n[*3];
  endsequence
  sequence s_strobe_rise;
    flash_we_n ##0 !flash_ce_n ##0 flash_dq_oe;
  endsequence

  // Never fight the device while it may drive
  property p_no_drive_on_read;
    !flash_oe_n |-> !flash_dq_oe;
  endproperty
  a_no_drive_on_read: assert property (p_no_drive_on_read)
    else $error("data driven while output enable low");

  // Strobe only under select, data driven
  property p_strobe_selected;
    !flash_we_n |-> !flash_ce_n && flash_dq_oe && flash_oe_n;
  endproperty
  a_strobe_selected: assert property (p_strobe_selected)
    else $error("write strobe without select or data");

  // Strobe pulse width, then rise with select and data held
  property p_strobe_shape;
    $fell(flash_we_n) |-> s_strobe_low ##1 s_strobe_rise;
  endproperty
  a_strobe_shape: assert property (p_strobe_shape)
    else $error("strobe width or rising edge wrong");

  // Address and data stable across the rising strobe edge
  property p_stable_at_rise;
    $rose(flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_out)
      ##1 $stable(flash_addr) && $stable(flash_dq_out);
  endproperty
  a_stable_at_rise: assert property (p_stable_at_rise)
    else $error("address or data moved at strobe edge");

  // Reset low keeps the bus quiet and refuses commands
  property p_reset_quiet;
    !flash_reset_powerdown_n |-> flash_ce_n && !flash_dq_oe && !cmd_ready;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("activity while device held in reset");

  // Read returns data within the access window
  property p_read_done;
    $fell(flash_oe_n) |-> ##[1:7] rd_valid ##0 flash_oe_n;
  endproperty
  a_read_done: assert property (p_read_done)
    else $error("read did not complete in time");

  // Address fixed for the whole read or write cycle
  property p_addr_held;
    !flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr);
  endproperty
  a_addr_held: assert property (p_addr_held)
    else $error("address changed during a cycle");

  // Ready returns only after the wake delay
  property p_wake_wait;
    $rose(flash_reset_powerdown_n) |-> !cmd_ready[*8];
  endproperty
  a_wake_wait: assert property (p_wake_wait)
    else $error("command ready too soon after reset release");
endmodule

/* afbi_host_bench.sv */
// Self-checking bench for the flash host, with a behavioural flash.
// Assumes afbi_pkg is compiled first; one 50 MHz clock.
module afbi_host_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import afbi_pkg::*;
  logic ref_clk, sys_rst, cmd_valid, cmd_write, pdown_req, protect_en, vpp_req;
  logic cmd_ready, rd_valid, pdown_active, dq_oe, ce_n, oe_n, we_n, wp_n, vpp_en;
  logic reset_powerdown_n;
  logic [21:0] cmd_addr, f_addr;
  afbi_data_t cmd_wdata, rd_data, dq_out, dq_in, got;
  int n_mismatch = 0;
  int n_checks = 0;
  // --------------------------------------------------------------------
  // Clock, design and device
  // --------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  afbi_host #(.ADDR_TOP(21)) afbi_host_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rd_data(rd_data), .rd_valid(rd_valid),
    .pdown_req(pdown_req), .protect_en(protect_en), .vpp_req(vpp_req),
    .pdown_active(pdown_active), .flash_addr(f_addr), .flash_dq_in(dq_in),
    .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
    .flash_we_n(we_n), .flash_reset_powerdown_n(reset_powerdown_n), .flash_wp_n(wp_n),
    .flash_vpp_en(vpp_en));
  afbi_flash_model afbi_flash_model_inst (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .reset_powerdown_n(reset_powerdown_n), .vpp_en(vpp_en), .addr(f_addr),
    .host_dq(dq_out), .host_oe(dq_oe),
    .dq_pin(dq_in));
  // --------------------------------------------------------------------
  // Compare and transfer tasks
  // --------------------------------------------------------------------
  task automatic chk_bit(input string what, input logic exp, input logic seen);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic chk_val(input string what, input logic [21:0] exp, input logic [21:0] seen);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One request; pins watched every cycle until done
  task automatic xfer(input logic w, input logic [21:0] a, input afbi_data_t d);
    int n;
    int strobes;
    logic ok;
    n = 0;
    strobes = 0;
    ok = 1'b1;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_wdata <= d;
    #1;
    while (cmd_ready !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
      if (ce_n === 1'b0 && f_addr !== a) ok = 1'b0;
      if (w && ce_n === 1'b0 && (dq_oe !== 1'b1 || dq_out !== d || oe_n !== 1'b1)) ok = 1'b0;
      if (!w && dq_oe !== 1'b0) ok = 1'b0;
      if (we_n === 1'b0) begin
        strobes++;
        if (ce_n !== 1'b0) ok = 1'b0;
      end
    end while ((w ? cmd_ready : rd_valid) !== 1'b1 && n < 12);
    got = rd_data;
    chk_bit("pin_rules", 1'b1, ok);
    chk_val("strobe_cycles", w ? 22'h3 : 22'h0, 22'(strobes));
    chk_bit("done_in_time", 1'b1, n < 12);
  endtask
  task automatic wait_ready(output int n);
    n = 0;
    while (cmd_ready !== 1'b1 && n < 40) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
  endtask
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_reset();
    int n;
    chk_bit("pwrdn_pin_low", 1'b0, reset_powerdown_n);
    chk_bit("pdown_flag", 1'b1, pdown_active);
    chk_bit("bus_free", 1'b0, dq_oe | ~ce_n);
    wait_ready(n);
    chk_bit("wake_time", 1'b1, n >= 13 && n < 40);
    chk_bit("pwrdn_pin_high", 1'b1, reset_powerdown_n);
    $display("test reset done");
  endtask
  task automatic t_pins();
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      protect_en <= ~i[0];
      vpp_req <= i[0];
      repeat (2) @(posedge ref_clk);
      #1;
      chk_bit("wp_pin", i[0], wp_n);
      chk_bit("vpp_pin", i[0], vpp_en);
    end
    $display("test pins done");
  endtask
  task automatic t_data();
    xfer(1'b1, 22'h000003, 16'h1234);
    xfer(1'b1, 22'h200003, 16'hBEEF);
    xfer(1'b0, 22'h000003, 16'h0000);
    chk_val("read_low", 22'h1234, 22'(got));
    xfer(1'b0, 22'h200003, 16'h0000);
    chk_val("read_top", 22'hBEEF, 22'(got));
    @(posedge ref_clk);
    vpp_req <= 1'b0;
    xfer(1'b1, 22'h000005, 16'h5555);
    xfer(1'b0, 22'h000005, 16'h0000);
    chk_val("lockout_read", 22'hC005, 22'(got));
    @(posedge ref_clk);
    vpp_req <= 1'b1;
    $display("test data done");
  endtask
  task automatic t_pdown();
    int n;
    @(posedge ref_clk);
    pdown_req <= 1'b1;
    repeat (12) @(posedge ref_clk);
    #1;
    chk_bit("pd_pin", 1'b0, reset_powerdown_n);
    chk_bit("pd_flag", 1'b1, pdown_active);
    chk_bit("pd_ready", 1'b0, cmd_ready);
    chk_bit("pd_bus", 1'b0, dq_oe | ~ce_n);
    @(posedge ref_clk);
    pdown_req <= 1'b0;
    #1;
    wait_ready(n);
    chk_bit("pd_wake", 1'b1, n >= 8 && n < 40);
    xfer(1'b0, 22'h000003, 16'h0000);
    chk_val("pd_read", 22'h1234, 22'(got));
    $display("test pdown done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // --------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_addr = 22'h0;
    cmd_wdata = 16'h0;
    pdown_req = 1'b0;
    protect_en = 1'b0;
    vpp_req = 1'b0;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
    t_reset();
    t_pins();
    t_data();
    t_pdown();
    close_out();
  end
  initial begin
    repeat (2000) @(posedge ref_clk);
    n_mismatch++;
    $display("timeout reached");
    close_out();
  end
endmodule

/* afbi_pkg.sv */
// Types shared by the asynchronous flash bus host.
// Assumes afbi_cfg.svh is on the include path.
`include "afbi_cfg.svh"
package afbi_pkg;
  // ----------------------------------------------------------------------
  // Sequencer states, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [7:0] {
    AFBI_IDLE   = 8'h01,
    AFBI_SETUP  = 8'h02,
    AFBI_STROBE = 8'h04,
    AFBI_HOLD   = 8'h08,
    AFBI_READ   = 8'h10,
    AFBI_PDOWN  = 8'h20,
    AFBI_WAKE   = 8'h40,
    AFBI_SPARE  = 8'h80
  } afbi_state_t;

  typedef logic [`AFBI_CNT_W-1:0] afbi_cnt_t;
  typedef logic [`AFBI_DATA_W-1:0] afbi_data_t;
  typedef logic [`AFBI_TOP_ADDR_MAX:0] afbi_addr_t;

  // All state of the host in one word
  typedef struct packed {
    afbi_state_t st;
    afbi_cnt_t cnt;
    afbi_addr_t addr;
    afbi_data_t wdata;
    afbi_data_t rdata;
    afbi_data_t dq_s1;
    afbi_data_t dq_s2;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_powerdown_n;
    logic pdown;
    logic wp_n;
    logic vpp_en;
    logic dq_oe;
    logic ready;
    logic rd_valid;
  } afbi_regs_t;
endpackage
